// >>> rtl/dda_consts.svh
`ifndef DDA_CONSTS_SVH
`define DDA_CONSTS_SVH

`define DDA_ADDR_W        8
`define DDA_DATA_W        32
`define DDA_OFS_CTRL      8'h00
`define DDA_OFS_AUTO_TIME 8'h04
`define DDA_OFS_AUTO_MAX  8'h08
`define DDA_OFS_STATUS    8'h0C
`define DDA_OFS_IRQ_STAT  8'h10
`define DDA_OFS_IRQ_MASK  8'h14

`define DDA_DIR_SEL_W     5
`define DDA_ACK_SEL_W     3
`define DDA_TIME_W        10
`define DDA_MAX_W         9
`define DDA_RUN_W         19
`define DDA_IRQ_W         4

`define DDA_DIR_SEL_RST   5'h00
`define DDA_ACK_SEL_RST   3'h4
`define DDA_TIME_RST      10'h000
`define DDA_MAX_RST       9'h005
`define DDA_DIR_SEL_MAX   5'h10
`define DDA_ACK_SEL_MAX   3'h7
`define DDA_TIME_MAX      10'h3E8
`define DDA_MAX_MAX       9'h1F4

`define DDA_CTRL_ACK_LSB  8
`define DDA_CTRL_AIN_LSB  12
`define DDA_STAT_CNT_LSB  16

`define DDA_IRQ_DIR       0
`define DDA_IRQ_ERR       1
`define DDA_IRQ_CLR       2
`define DDA_IRQ_FATAL     3

`define DDA_SEC_NS        1000000000
`define DDA_CLK_NS        8
`define DDA_SEC_CYC       (`DDA_SEC_NS / `DDA_CLK_NS)

`endif

// >>> rtl/dda_pkg.sv
`include "dda_consts.svh"

package dda_pkg;

  typedef struct packed {
    logic [1:0]                ain_dig;
    logic [`DDA_ACK_SEL_W-1:0] ack_sel;
    logic [`DDA_DIR_SEL_W-1:0] dir_sel;
  } dda_cfg_t;

  typedef struct packed {
    logic       ack;
    logic       two;
    logic       one;
    logic       rev;
  } dda_keys_t;

  typedef struct packed {
    logic [`DDA_ADDR_W-1:0] addr;
    logic [`DDA_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } dda_bus_t;

  typedef enum logic [2:0] {
    DDA_ERR_NONE  = 3'h1,
    DDA_ERR_HELD  = 3'h2,
    DDA_ERR_FATAL = 3'h4
  } dda_err_t;

endpackage : dda_pkg

// >>> rtl/dda_top.sv
`timescale 1ns/10ps
`include "dda_consts.svh"
module dda_top #(
  parameter int unsigned P_SEC_CYC = `DDA_SEC_CYC
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  input  wire dda_pkg::dda_bus_t      i_bus,
  output logic [`DDA_DATA_W-1:0]      o_rdata,
  input  wire logic [3:0]             i_din,
  input  wire logic [1:0]             i_ain,
  input  wire dda_pkg::dda_keys_t     i_keys,
  input  wire logic                   i_target_neg,
  input  wire logic                   i_motor_running,
  input  wire logic                   i_virt_out,
  input  wire logic                   i_fault_event,
  input  wire logic                   i_fault_present,
  input  wire logic                   i_current_ok,
  output logic                        o_dir_back,
  output logic                        o_err_latched,
  output logic                        o_err_fatal,
  output logic                        o_ack_pulse,
  output logic                        o_irq
);
  import dda_pkg::*;

  localparam int NIN = 10;
  localparam int SEC_W = $clog2(P_SEC_CYC + 1);

  // Synchronised pins: din[3:0], ain[5:4], keys[9:6]
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [NIN-1:0] sync3_q;
  logic [NIN-1:0] rise;

  assign raw_in = {i_keys, i_ain, i_din};

  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= raw_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end
      assign rise[g] = sync2_q[g] & ~sync3_q[g];
    end
  endgenerate

  wire [3:0] din_s   = sync2_q[3:0];
  wire [1:0] ain_s   = sync2_q[5:4];
  wire [3:0] din_r   = rise[3:0];
  wire [1:0] ain_r   = rise[5:4];
  wire       rev_r   = rise[6];
  wire       one_r   = rise[7];
  wire       two_r   = rise[8];
  wire       ack_r   = rise[9];

  // Configuration and interrupt registers
  dda_cfg_t                 cfg_q;
  logic [`DDA_TIME_W-1:0]   auto_time_q;
  logic [`DDA_MAX_W-1:0]    auto_max_q;
  logic [`DDA_IRQ_W-1:0]    irq_stat_q;
  logic [`DDA_IRQ_W-1:0]    irq_mask_q;
  logic [`DDA_IRQ_W-1:0]    irq_ev;
  logic [`DDA_DATA_W-1:0]   rdata_q;
  logic [`DDA_DATA_W-1:0]   rdata_d;

  wire wr_ctrl = i_bus.wr && (i_bus.addr == `DDA_OFS_CTRL);
  wire wr_time = i_bus.wr && (i_bus.addr == `DDA_OFS_AUTO_TIME);
  wire wr_max  = i_bus.wr && (i_bus.addr == `DDA_OFS_AUTO_MAX);
  wire wr_ist  = i_bus.wr && (i_bus.addr == `DDA_OFS_IRQ_STAT);
  wire wr_imsk = i_bus.wr && (i_bus.addr == `DDA_OFS_IRQ_MASK);

  wire [`DDA_DIR_SEL_W-1:0] w_dir = i_bus.wdata[`DDA_DIR_SEL_W-1:0];
  wire [`DDA_ACK_SEL_W-1:0] w_ack =
    i_bus.wdata[`DDA_CTRL_ACK_LSB +: `DDA_ACK_SEL_W];
  wire [`DDA_TIME_W-1:0]    w_time = i_bus.wdata[`DDA_TIME_W-1:0];
  wire [`DDA_MAX_W-1:0]     w_max  = i_bus.wdata[`DDA_MAX_W-1:0];

  // Out-of-range settings are dropped, the old value stays
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q.dir_sel <= `DDA_DIR_SEL_RST;
      cfg_q.ack_sel <= `DDA_ACK_SEL_RST;
      cfg_q.ain_dig <= 2'h0;
    end else if (wr_ctrl) begin
      if (w_dir <= `DDA_DIR_SEL_MAX) begin
        cfg_q.dir_sel <= w_dir;
      end
      cfg_q.ack_sel <= w_ack;
      cfg_q.ain_dig <= i_bus.wdata[`DDA_CTRL_AIN_LSB +: 2];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      auto_time_q <= `DDA_TIME_RST;
      auto_max_q  <= `DDA_MAX_RST;
    end else begin
      if (wr_time && (w_time <= `DDA_TIME_MAX)) begin
        auto_time_q <= w_time;
      end
      if (wr_max && (w_max <= `DDA_MAX_MAX)) begin
        auto_max_q <= w_max;
      end
    end
  end

  // Direction selection
  logic dir_q;
  logic dir_d;
  wire  running = i_motor_running;

  function automatic logic keys_dir(input logic cur, input logic f, input logic b);
    keys_dir = b ? 1'b1 : (f ? 1'b0 : cur);
  endfunction

  always_comb begin
    dir_d = dir_q;
    case (cfg_q.dir_sel)
      5'h00: dir_d = i_target_neg;
      5'h01: dir_d = 1'b0;
      5'h02: dir_d = 1'b1;
      5'h03: dir_d = din_s[0];
      5'h04: dir_d = din_s[1];
      5'h05: dir_d = din_s[2];
      5'h06: dir_d = din_s[3];
      5'h08: dir_d = cfg_q.ain_dig[0] ? ain_s[0] : dir_q;
      5'h09: dir_d = cfg_q.ain_dig[1] ? ain_s[1] : dir_q;
      5'h0A: dir_d = (rev_r && running) ? ~dir_q : dir_q;
      5'h0B: dir_d = keys_dir(dir_q, one_r, two_r);
      5'h0C: dir_d = running ? dir_q : keys_dir(dir_q, one_r, two_r);
      5'h0D: dir_d = i_virt_out;
      5'h0E: dir_d = (rev_r && running) ? ~dir_q : dir_q;
      5'h0F: dir_d = keys_dir(dir_q, one_r, two_r);
      5'h10: dir_d = running ? dir_q : keys_dir(dir_q, one_r, two_r);
      default: dir_d = dir_q;
    endcase
  end

  // Setting 7 has no source here and holds the last direction
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dir_q <= 1'b0;
    end else begin
      dir_q <= dir_d;
    end
  end

  // Manual acknowledge source
  function automatic logic ack_src(input logic [`DDA_ACK_SEL_W-1:0] sel,
                                   input logic [3:0] dr, input logic kr,
                                   input logic [1:0] ar, input logic [1:0] en);
    case (sel)
      3'h1:    ack_src = dr[0];
      3'h2:    ack_src = dr[1];
      3'h3:    ack_src = dr[2];
      3'h4:    ack_src = dr[3];
      3'h5:    ack_src = kr;
      3'h6:    ack_src = ar[0] & en[0];
      3'h7:    ack_src = ar[1] & en[1];
      default: ack_src = 1'b0;
    endcase
  endfunction

  wire man_ack = ack_src(cfg_q.ack_sel, din_r, ack_r, ain_r, cfg_q.ain_dig);

  // One-second tick shared by the wait and run timers
  logic [SEC_W-1:0] pre_q;
  wire              tick = (pre_q == SEC_W'(P_SEC_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_q <= '0;
    end else begin
      pre_q <= tick ? '0 : pre_q + 1'b1;
    end
  end

  // Error state
  dda_err_t                err_q;
  dda_err_t                err_d;
  logic [`DDA_TIME_W-1:0]  wait_q;
  logic [`DDA_MAX_W-1:0]   cnt_q;
  logic [`DDA_RUN_W-1:0]   run_q;
  logic                    ack_q;

  wire held     = (err_q == DDA_ERR_HELD);
  wire auto_on  = (auto_time_q != '0);
  // wait has reached the set time
  wire auto_due = held && auto_on && (wait_q >= auto_time_q);
  wire limit_hit = (auto_max_q != '0) && (cnt_q >= auto_max_q);
  // only once the fault is gone
  wire can_ack  = held && !i_fault_present;
  wire do_man   = can_ack && man_ack;
  wire do_auto  = can_ack && auto_due && !do_man && !limit_hit;
  wire do_fatal = can_ack && auto_due && !do_man && limit_hit;
  wire [`DDA_RUN_W-1:0] run_lim = `DDA_RUN_W'(auto_max_q * auto_time_q);
  wire run_ok   = (err_q == DDA_ERR_NONE) && running && i_current_ok;
  wire run_done = run_ok && (run_q >= run_lim);

  always_comb begin
    err_d = err_q;
    case (err_q)
      DDA_ERR_NONE:  err_d = i_fault_event ? DDA_ERR_HELD : DDA_ERR_NONE;
      DDA_ERR_HELD: begin
        if (do_fatal) begin
          err_d = DDA_ERR_FATAL;
        end else if (do_man || do_auto) begin
          err_d = DDA_ERR_NONE;
        end
      end
      DDA_ERR_FATAL: err_d = DDA_ERR_FATAL;
      default:       err_d = DDA_ERR_HELD;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_q <= DDA_ERR_NONE;
      ack_q <= 1'b0;
    end else begin
      err_q <= err_d;
      ack_q <= do_man || do_auto;
    end
  end

  // seconds spent in the held state
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q <= '0;
    end else if (!held) begin
      wait_q <= '0;
    end else if (tick && (wait_q != `DDA_TIME_MAX)) begin
      wait_q <= wait_q + 1'b1;
    end
  end

  // count auto acknowledges; clear after run period
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else if (do_auto) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (run_done) begin
      cnt_q <= '0;
    end
  end

  // run time restarts on any error
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_q <= '0;
    end else if (err_q != DDA_ERR_NONE) begin
      run_q <= '0;
    end else if (run_ok && tick && !run_done) begin
      run_q <= run_q + 1'b1;
    end
  end

  // Interrupt status, set wins over write-one-clear
  assign irq_ev[`DDA_IRQ_DIR]   = (dir_d != dir_q);
  assign irq_ev[`DDA_IRQ_ERR]   = (err_q == DDA_ERR_NONE) && i_fault_event;
  assign irq_ev[`DDA_IRQ_CLR]   = do_man || do_auto;
  assign irq_ev[`DDA_IRQ_FATAL] = do_fatal;

  wire [`DDA_IRQ_W-1:0] ist_clr = wr_ist ? i_bus.wdata[`DDA_IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~ist_clr) | irq_ev;
      if (wr_imsk) begin
        irq_mask_q <= i_bus.wdata[`DDA_IRQ_W-1:0];
      end
    end
  end

  // Read path, one cycle late; unmapped reads zero
  always_comb begin
    rdata_d = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `DDA_OFS_CTRL: begin
          rdata_d[`DDA_DIR_SEL_W-1:0] = cfg_q.dir_sel;
          rdata_d[`DDA_CTRL_ACK_LSB +: `DDA_ACK_SEL_W] = cfg_q.ack_sel;
          rdata_d[`DDA_CTRL_AIN_LSB +: 2] = cfg_q.ain_dig;
        end
        `DDA_OFS_AUTO_TIME: rdata_d[`DDA_TIME_W-1:0] = auto_time_q;
        `DDA_OFS_AUTO_MAX:  rdata_d[`DDA_MAX_W-1:0]  = auto_max_q;
        `DDA_OFS_STATUS: begin
          rdata_d[0] = dir_q;
          rdata_d[1] = held;
          rdata_d[2] = (err_q == DDA_ERR_FATAL);
          rdata_d[`DDA_STAT_CNT_LSB +: `DDA_MAX_W] = cnt_q;
        end
        `DDA_OFS_IRQ_STAT:  rdata_d[`DDA_IRQ_W-1:0] = irq_stat_q;
        `DDA_OFS_IRQ_MASK:  rdata_d[`DDA_IRQ_W-1:0] = irq_mask_q;
        default:            rdata_d = '0;
      endcase
    end
  end

  logic irq_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      irq_q   <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign o_rdata       = rdata_q;
  assign o_dir_back    = dir_q;
  assign o_err_latched = err_q[1];
  assign o_err_fatal   = err_q[2];
  assign o_ack_pulse   = ack_q;
  assign o_irq         = irq_q;

endmodule : dda_top

// >>> tb/dda_top_asserts.sv
`timescale 1ns/10ps
module dda_top_chk #(
  parameter int unsigned P_SEC_CYC = 10
) (
  input wire logic              i_clk,
  input wire logic              i_rstn,
  input wire dda_pkg::dda_bus_t i_bus,
  input wire logic [3:0]        i_din,
  input wire logic              i_target_neg,
  input wire logic              i_virt_out,
  input wire logic              i_fault_event,
  input wire logic              i_fault_present,
  input wire logic              o_dir_back,
  input wire logic              o_err_latched,
  input wire logic              o_err_fatal,
  input wire logic              o_ack_pulse
);
  import dda_pkg::*;
  logic [4:0] sel_q;
  // Shadow of the selector; out-of-range writes leave it alone
  wire        sel_wr = i_bus.wr && i_bus.addr == 8'h00 && i_bus.wdata[4:0] <= 5'h10;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) sel_q <= 5'h00;
    else if (sel_wr) sel_q <= i_bus.wdata[4:0];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_sel(logic [4:0] v);
    (sel_q == v) [*2];
  endsequence
  sequence s_pin(logic [4:0] v);
    (sel_q == v) [*4];
  endsequence
  sequence s_idle_fault;
    !o_err_latched && !o_err_fatal && i_fault_event;
  endsequence
  a_dir_target: assert property (s_sel(5'h00) |-> o_dir_back == $past(i_target_neg))
    else $error("direction does not follow target sign");
  a_fixed_fwd: assert property (s_sel(5'h01) |-> !o_dir_back)
    else $error("fixed forward broken");
  a_fixed_back: assert property (s_sel(5'h02) |-> o_dir_back)
    else $error("fixed backward broken");
  a_din_first: assert property (s_pin(5'h03) |-> o_dir_back == $past(i_din[0], 3))
    else $error("direction does not follow input one");
  a_din_last: assert property (s_pin(5'h06) |-> o_dir_back == $past(i_din[3], 3))
    else $error("direction does not follow input four");
  a_virt_follow: assert property (s_sel(5'h0D) |-> o_dir_back == $past(i_virt_out))
    else $error("direction does not follow virtual output");
  a_fault_latch: assert property (s_idle_fault |=> o_err_latched)
    else $error("fault not latched");
  a_fault_hold: assert property (o_err_latched && i_fault_present |=> o_err_latched)
    else $error("error cleared while fault present");
  a_ack_clears: assert property (o_ack_pulse |-> !o_err_latched &&
    $past(o_err_latched) && !$past(i_fault_present))
    else $error("acknowledge pulse without valid clear");
  a_fatal_sticky: assert property (o_err_fatal |=> o_err_fatal)
    else $error("fatal error left without reset");
endmodule : dda_top_chk

bind dda_top dda_top_chk #(.P_SEC_CYC(P_SEC_CYC)) dda_top_chk_inst (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus), .i_din(i_din), .i_target_neg(i_target_neg),
  .i_virt_out(i_virt_out), .i_fault_event(i_fault_event), .i_fault_present(i_fault_present),
  .o_dir_back(o_dir_back), .o_err_latched(o_err_latched), .o_err_fatal(o_err_fatal),
  .o_ack_pulse(o_ack_pulse));

// >>> tb/dda_panel.sv
`timescale 1ns/10ps
module dda_panel #(
  parameter int P_HOLD = 6
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire dda_pkg::dda_keys_t i_press,
  output dda_pkg::dda_keys_t      o_keys
);
  import dda_pkg::*;
  logic [3:0] cnt_q;
  dda_keys_t  keys_q;
  // Held like a finger press, longer than the synchroniser needs
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      keys_q <= '0;
      cnt_q  <= 4'h0;
    end else if (|i_press) begin
      keys_q <= i_press;
      cnt_q  <= 4'(P_HOLD);
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      keys_q <= '0;
    end
  end
  assign o_keys = keys_q;
endmodule : dda_panel

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
  import dda_pkg::*;
  logic        i_clk, i_rstn, tneg, run, virt, fev, fpres, cur_ok;
  logic        dir, err, fatal, ackp, irq;
  logic [31:0] rdata;
  logic [3:0]  din;
  logic [1:0]  ain;
  dda_bus_t    bus;
  dda_keys_t   keys, press;
  int          failures = 0, num_checks = 0, cyc = 0;

  dda_top #(.P_SEC_CYC(10)) dda_top_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(bus),
    .o_rdata(rdata), .i_din(din), .i_ain(ain), .i_keys(keys), .i_target_neg(tneg),
    .i_motor_running(run), .i_virt_out(virt), .i_fault_event(fev), .i_fault_present(fpres),
    .i_current_ok(cur_ok), .o_dir_back(dir), .o_err_latched(err), .o_err_fatal(fatal),
    .o_ack_pulse(ackp), .o_irq(irq));
  dda_panel dda_panel_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_press(press), .o_keys(keys));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      give_verdict;
    end
  end

  task give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge i_clk);
  endtask : rd
  function automatic logic [31:0] ctrl(input int s, input int a, input int g);
    return 32'((g << 12) | (a << 8) | s);
  endfunction : ctrl
  task key(input logic [3:0] k, input logic e);
    press <= dda_keys_t'(k);
    @(posedge i_clk);
    press <= '0;
    repeat (12) @(posedge i_clk);
    chk(dir, e);
  endtask : key
  task flt;
    fev <= 1'b1;
    @(posedge i_clk);
    fev <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(err, 1'b1);
  endtask : flt
  task ack_try(input int s, input logic e);
    logic seen;
    seen = 1'b0;
    if (s >= 1 && s <= 4) din <= 4'(1 << (s - 1));
    if (s == 5) press <= dda_keys_t'(4'h8);
    if (s >= 6) ain <= 2'(1 << (s - 6));
    repeat (10) begin
      @(posedge i_clk);
      press <= '0;
      #1 if (ackp === 1'b1) seen = 1'b1;
    end
    @(posedge i_clk);
    din <= 4'h0;
    ain <= 2'h0;
    repeat (4) @(posedge i_clk);
    chk(seen, e);
    chk(err, !e);
  endtask : ack_try

  task t_regs;
    rd(8'h00, 32'h00000400);
    rd(8'h04, 32'h00000000);
    rd(8'h08, 32'h00000005);
    rd(8'h18, 32'h00000000);
    wr(8'h04, 32'h000003E9);
    rd(8'h04, 32'h00000000);
    wr(8'h08, 32'h000001F5);
    rd(8'h08, 32'h00000005);
  endtask : t_regs
  task t_dir;
    int s;
    for (s = 0; s < 14; s++) if (s != 7 && (s < 10 || s == 13)) begin
      wr(8'h00, ctrl(s, 4, 3));
      tneg <= 1'b1;
      virt <= 1'b1;
      din  <= (s >= 3 && s <= 6) ? 4'(1 << (s - 3)) : 4'h0;
      ain  <= (s == 8) ? 2'h1 : (s == 9) ? 2'h2 : 2'h0;
      repeat (6) @(posedge i_clk);
      chk(dir, s != 1);
      {tneg, virt, din, ain} <= '0;
      repeat (6) @(posedge i_clk);
      chk(dir, s == 2);
    end
    wr(8'h00, ctrl(8, 4, 2));
    ain <= 2'h1;
    repeat (6) @(posedge i_clk);
    chk(dir, 1'b0);
    ain <= 2'h0;
    wr(8'h00, ctrl(17, 4, 3));
    rd(8'h00, ctrl(8, 4, 3));
  endtask : t_dir
  task t_keys;
    run <= 1'b1;
    wr(8'h00, ctrl(11, 4, 3));
    key(4'h4, 1'b1);
    key(4'h2, 1'b0);
    wr(8'h00, ctrl(12, 4, 3));
    key(4'h4, 1'b0);
    run <= 1'b0;
    key(4'h4, 1'b1);
    wr(8'h00, ctrl(10, 4, 3));
    key(4'h1, 1'b1);
    run <= 1'b1;
    key(4'h1, 1'b0);
    wr(8'h00, ctrl(14, 4, 3));
    key(4'h1, 1'b1);
    run <= 1'b0;
    key(4'h1, 1'b1);
    wr(8'h00, ctrl(15, 4, 3));
    key(4'h0, 1'b1);
    key(4'h2, 1'b0);
    wr(8'h00, ctrl(16, 4, 3));
    run <= 1'b1;
    key(4'h4, 1'b0);
    run <= 1'b0;
    key(4'h4, 1'b1);
    wr(8'h00, ctrl(0, 4, 3));
  endtask : t_keys
  task t_ack;
    int s;
    for (s = 1; s < 8; s++) begin
      fpres <= 1'b1;
      flt;
      wr(8'h00, ctrl(0, s, 3));
      ack_try(s, 1'b0);
      fpres <= 1'b0;
      ack_try(s, 1'b1);
    end
    flt;
    wr(8'h00, ctrl(0, 0, 3));
    ack_try(1, 1'b0);
    wr(8'h00, ctrl(0, 6, 0));
    ack_try(6, 1'b0);
    wr(8'h00, ctrl(0, 4, 3));
    ack_try(4, 1'b1);
  endtask : t_ack
  task t_irq;
    rd(8'h10, 32'h00000007);
    wr(8'h10, 32'h0000000F);
    wr(8'h14, 32'h00000000);
    flt;
    chk(irq, 1'b0);
    rd(8'h10, 32'h00000002);
    wr(8'h14, 32'h00000002);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b1);
    wr(8'h10, 32'h00000002);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b0);
    ack_try(4, 1'b1);
    rd(8'h10, 32'h00000004);
  endtask : t_irq
  task t_auto;
    flt;
    repeat (40) @(posedge i_clk);
    chk(err, 1'b1);
    ack_try(4, 1'b1);
    wr(8'h04, 32'h00000002);
    wr(8'h08, 32'h00000002);
    rd(8'h04, 32'h00000002);
    rd(8'h08, 32'h00000002);
    flt;
    ack_try(4, 1'b1);
    flt;
    repeat (40) @(posedge i_clk);
    chk(err, 1'b0);
    rd(8'h0C, 32'h00010000);
    {run, cur_ok} <= 2'h3;
    repeat (60) @(posedge i_clk);
    rd(8'h0C, 32'h00000000);
    run <= 1'b0;
    repeat (2) begin
      flt;
      repeat (40) @(posedge i_clk);
    end
    rd(8'h0C, 32'h00020000);
    flt;
    repeat (40) @(posedge i_clk);
    chk(fatal, 1'b1);
    rd(8'h0C, 32'h00020004);
    rd(8'h10, 32'h0000000E);
    din <= 4'h8;
    repeat (6) @(posedge i_clk);
    din <= 4'h0;
    repeat (4) @(posedge i_clk);
    chk(fatal, 1'b1);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(fatal, 1'b0);
  endtask : t_auto

  initial begin
    i_rstn = 1'b0;
    bus    = '0;
    press  = '0;
    din    = 4'h0;
    ain    = 2'h0;
    {tneg, run, virt, fev, fpres, cur_ok} = '0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    t_regs;
    t_dir;
    t_keys;
    t_ack;
    t_irq;
    t_auto;
    give_verdict;
  end
endmodule : tb
